// ### dv/omrc_ctrl_properties.sv
`timescale 1ns/1ps

module omrc_ctrl_properties (
	// Clock and reset
	input logic                clk,
	input logic                resetn,
	// Watched ports
	input logic                reg_read,
	input logic [7:0]          reg_rdata,
	input logic                sleep_exec,
	input logic                external_reset_pin_n,
	input omrc_pkg::omrc_rst_t rst_src,
	input omrc_pkg::omrc_ctl_t ctl,
	input logic                reset_active
);
	import omrc_pkg::*;

	// One clock domain
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// Mode and gating relations
	a_no_run_reset: assert property (reset_active |-> !ctl.cpu_run)
		else $error("cpu runs in reset process");
	a_run_after_reset: assert property ($fell(reset_active) |-> ##[0:2] ctl.cpu_run && ctl.slow_osc_en)
		else $error("no run after reset");
	a_sleep_halts: assert property (sleep_exec && ctl.cpu_run && !reset_active |-> ##[1:3] !ctl.slow_osc_en)
		else $error("sleep did not halt");
	a_halt_all_off: assert property (!ctl.slow_osc_en |-> !ctl.cpu_run && !ctl.timer0_run)
		else $error("activity with slow osc off");
	a_stop_periph: assert property (!ctl.cpu_run |-> !ctl.periph_en)
		else $error("peripherals on while stopped");
	a_fast_stop_slow: assert property (!ctl.fast_osc_en && ctl.cpu_run |-> !ctl.sys_clk_fast)
		else $error("fast clock used while stopped");
	a_t0_slow_clk: assert property (ctl.timer0_slow_clk |-> ctl.slow_osc_en)
		else $error("timer0 slow clock without osc");
	a_por_reset: assert property (rst_src.power_on |-> ##[1:4] reset_active)
		else $error("power-on did not reset");
	a_pin_reset: assert property (!external_reset_pin_n |-> ##[1:4] reset_active)
		else $error("pin did not reset");
	a_vector_pulse: assert property (ctl.goto_vector |=> !ctl.goto_vector)
		else $error("vector pulse too long");
	a_read_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
		else $error("read data outside slot");

	// Main scenarios
	c_vector: cover property (ctl.goto_vector);
	c_sleep: cover property (sleep_exec && ctl.cpu_run);
	c_reset_end: cover property ($fell(reset_active));
endmodule : omrc_ctrl_properties

bind omrc_ctrl omrc_ctrl_properties u_omrc_ctrl_properties (.clk, .resetn, .reg_read, .reg_rdata,
	.sleep_exec, .external_reset_pin_n, .rst_src, .ctl, .reset_active);

// ### dv/omrc_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; $display("[ERR] %0t %h %h", $time, a, b); end end

module omrc_ctrl_tb;
	import omrc_pkg::*;
	logic       clk = 0, resetn = 0, reg_write = 0, reg_read = 0, sleep_exec = 0, clrwdt_exec = 0;
	logic       global_irq_enable = 0, timer_zero_run_enable = 1, timer_one_run_enable = 1;
	logic       low_clock_to_timer_zero = 1, external_reset_pin_n = 1, reset_active, gv;
	logic [3:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, reg_rdata;
	omrc_wake_t wake_src = '0;
	omrc_rst_t  rst_src = '0;
	omrc_ctl_t  ctl;
	int         num_errors = 0, compares = 0, n;
	logic [3:0] rs[5] = '{4'h8, 4'h1, 4'h2, 4'h1, 4'h4};
	logic [7:0] ex[5] = '{8'h18, 8'h08, 8'h18, 8'h08, 8'h18};

	omrc_ctrl #(.PWRUP_A_CYC(100), .PWRUP_B_CYC(200), .PWRUP_C_CYC(400)) u_omrc_ctrl (.clk, .resetn,
		.reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .sleep_exec, .clrwdt_exec,
		.global_irq_enable, .timer_zero_run_enable, .timer_one_run_enable, .low_clock_to_timer_zero,
		.wake_src, .external_reset_pin_n, .rst_src, .ctl, .reset_active);

	// Clock
	initial begin
		forever #2 clk = ~clk;
	end

	// Verdict
	task stop_test;
		if (num_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test

	// Bus cycles and waits
	task wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'h1;
		@(posedge clk);
		reg_write <= 1'h0;
		@(posedge clk);
	endtask : wr

	task rd(input logic [3:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_read <= 1'h1;
		@(posedge clk);
		reg_read <= 1'h0;
		#1 `CHK(reg_rdata, e)
		@(posedge clk);
	endtask : rd

	task idle(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : idle

	task wrst;
		for (n = 0; reset_active !== 1'h0 && n < 2000; n++) idle(1);
	endtask : wrst

	task wwait(input int lim);
		gv = 0;
		for (n = 0; ctl.cpu_run !== 1'h1 && n < lim; n++) begin
			idle(1);
			gv |= ctl.goto_vector;
		end
		idle(1);
		gv |= ctl.goto_vector;
	endtask : wwait

	// Tests
	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1'h1;
		wrst;
		`CHK(n >= 116 && n <= 130, 1'h1)
		`CHK({ctl.fast_osc_en, ctl.slow_osc_en, ctl.sys_clk_fast, ctl.cpu_run}, 4'hf)
		rd(4'h3, 8'h08);
		rd(4'h0, 8'h01);
		rd(4'h5, 8'h00);
		wr(4'h0, 8'h00);
		idle(3);
		`CHK({ctl.fast_osc_en, ctl.sys_clk_fast, ctl.cpu_run}, 3'h5)
		wr(4'h0, 8'h02);
		idle(3);
		`CHK(ctl.fast_osc_en, 1'h0)
		wr(4'h0, 8'h01);
		idle(3);
		`CHK(ctl.sys_clk_fast & ctl.fast_osc_en, 1'h1)
		// Standby, woken by each source
		for (int i = 0; i < 5; i++) begin
			wr(4'h0, 8'h09);
			idle(3);
			`CHK({ctl.cpu_run, ctl.periph_en, ctl.slow_osc_en, ctl.timer0_run, ctl.timer1_run}, 5'h07)
			wake_src <= omrc_wake_t'(5'h10 >> i);
			wwait(6);
			wake_src <= '0;
			`CHK(ctl.cpu_run, 1'h1)
			idle(3);
		end
		rd(4'h0, 8'h01);
		wr(4'h2, 8'h20);
		idle(3);
		`CHK(ctl.timer0_slow_clk, 1'h1)
		// Halt by sleep, then by write with slow select
		for (int i = 0; i < 2; i++) begin
			wr(4'h2, i ? 8'h04 : 8'h00);
			global_irq_enable <= (i == 0);
			if (i == 0) begin
				sleep_exec <= 1'h1;
				@(posedge clk);
				sleep_exec <= 1'h0;
			end else
				wr(4'h0, 8'h04);
			idle(3);
			`CHK({ctl.fast_osc_en, ctl.slow_osc_en, ctl.cpu_run, ctl.periph_en}, 4'h0)
			rd(4'h1, 8'h10);
			wake_src <= 5'h18;
			wwait(10);
			`CHK(ctl.cpu_run, 1'h0)
			wake_src <= omrc_wake_t'(5'h04 >> (2 * i));
			wwait(600);
			wake_src <= '0;
			`CHK(n >= (i ? 512 : 16) && n <= (i ? 522 : 26), 1'h1)
			`CHK({gv, ctl.sys_clk_fast}, i ? 2'h0 : 2'h3)
			idle(3);
		end
		rd(4'h0, 8'h00);
		clrwdt_exec <= 1'h1;
		@(posedge clk);
		clrwdt_exec <= 1'h0;
		#1 `CHK(ctl.wdt_clear, 1'h1)
		idle(2);
		rd(4'h1, 8'h18);
		// Reset events and their flags
		foreach (rs[k]) begin
			{external_reset_pin_n, rst_src} <= rs[k] ^ 4'h8;
			idle(4);
			{external_reset_pin_n, rst_src} <= 4'h8;
			wrst;
			rd(4'h1, ex[k]);
			rd(4'h0, 8'h01);
		end
		stop_test;
	end

	// Hang guard
	initial begin
		#40000;
		num_errors++;
		stop_test;
	end
endmodule : omrc_ctrl_tb

// ### src/omrc_cfg.svh
`ifndef OMRC_CFG_SVH
`define OMRC_CFG_SVH

// Register addresses
`define OMRC_ADDR_OSC      4'h0
`define OMRC_ADDR_STATUS   4'h1
`define OMRC_ADDR_CONFIG   4'h2
`define OMRC_ADDR_MODE     4'h3

// Oscillator control fields
`define OMRC_HSEL_BIT      0
`define OMRC_HSTOP_BIT     1
`define OMRC_PMODE_LO      2
`define OMRC_PMODE_HI      3
`define OMRC_OSC_RESET     8'h01

// Power mode field encodings
`define OMRC_PM_RUN        2'b00
`define OMRC_PM_HALT       2'b01
`define OMRC_PM_STANDBY    2'b10

// Status fields
`define OMRC_PD_BIT        3
`define OMRC_TO_BIT        4

// Configuration fields
`define OMRC_CFG_PWRUP_LO  0
`define OMRC_CFG_PWRUP_HI  1
`define OMRC_CFG_FAST_LO   2
`define OMRC_CFG_FAST_HI   3
`define OMRC_CFG_SLOW_BIT  4
`define OMRC_CFG_T0SRC_BIT 5
`define OMRC_CFG_RESET     8'h00

// Timing figures
`define OMRC_CLK_MHZ       250
`define OMRC_PWRUP_MS_A    18
`define OMRC_PWRUP_MS_B    72
`define OMRC_PWRUP_MS_C    288
`define OMRC_OST_CYCLES    16
`define OMRC_WAKE_XTAL     512
`define OMRC_WAKE_RC       16

`endif

// ### src/omrc_ctrl.sv
// Function
// - After reset process, enter Normal mode
// - high_clock_select picks fast or slow clock
// - high_osc_stop stops fast osc except when selected in Normal; Halt stops it too
// - Mode field 10b requests Standby
// - Standby stops CPU; timers, slow clock run
// - Standby wakes on timer, watchdog, port, edge
// - Wake resumes per high_clock_select
// - Halt entry: sleep or 01b, flags, watchdog
// - Halt stops both oscillators and peripherals
// - Halt wakes on watchdog, port, edge only
// - Halt wake waits 512 or 16 cycles
// - Standby wake resumes immediately
// - Global irq enable picks vector branch
// - Clock select and Halt in one write
// - Reset on power-on, low voltage, pin, watchdog
// - Reset restores defined register values
// - Timeout and powerdown flags per event
// - Power-up wait of 18, 72, 288 ms
// - Then 16 fast cycles start-up wait
// - Slow clock may drive Timer0 in Normal
// - Crystal modes select long wake wait
`timescale 1ns/1ps
`include "omrc_cfg.svh"

module omrc_ctrl #(
	parameter int PWRUP_A_CYC = `OMRC_PWRUP_MS_A * `OMRC_CLK_MHZ * 1000,
	parameter int PWRUP_B_CYC = `OMRC_PWRUP_MS_B * `OMRC_CLK_MHZ * 1000,
	parameter int PWRUP_C_CYC = `OMRC_PWRUP_MS_C * `OMRC_CLK_MHZ * 1000
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              resetn,
	// Register port
	input  wire logic [3:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_write,
	input  wire logic              reg_read,
	output logic [7:0]             reg_rdata,
	// Core events
	input  wire logic              sleep_exec,
	input  wire logic              clrwdt_exec,
	input  wire logic              global_irq_enable,
	input  wire logic              timer_zero_run_enable,
	input  wire logic              timer_one_run_enable,
	input  wire logic              low_clock_to_timer_zero,
	input  omrc_pkg::omrc_wake_t   wake_src,
	// Reset sources from pins and analog
	input  wire logic              external_reset_pin_n,
	input  omrc_pkg::omrc_rst_t    rst_src,
	// Controls
	output omrc_pkg::omrc_ctl_t    ctl,
	output logic                   reset_active
);
	import omrc_pkg::*;

	localparam int CW = 30;

	omrc_state_t       state_reg;
	logic [7:0]        osc_reg;
	logic [7:0]        cfg_reg;
	logic              to_reg;
	logic              pd_reg;
	logic [CW-1:0]     cnt_reg;
	logic              vec_reg;
	logic [2:0]        rst_s1_reg;
	logic [2:0]        rst_s2_reg;
	logic              pin_s1_reg;
	logic              pin_s2_reg;
	omrc_wake_t        wk_s1_reg;
	omrc_wake_t        wk_s2_reg;
	logic [7:0]        rdata_reg;
	omrc_ctl_t         ctl_reg;
	logic              rstact_reg;

	logic              pin_rst;
	logic              any_rst;
	logic              wr_osc;
	logic [1:0]        pm_wr;
	logic              enter_halt;
	logic              enter_stby;
	logic              halt_wake;
	logic              stby_wake;
	logic              is_xtal;
	logic [CW-1:0]     pwrup_cyc;
	logic [CW-1:0]     wake_cyc;
	logic [7:0]        status_val;

	// Two-flop synchronisers for outside inputs
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_s1_reg <= 3'h0;
			rst_s2_reg <= 3'h0;
			pin_s1_reg <= 1'b1;
			pin_s2_reg <= 1'b1;
			wk_s1_reg  <= '0;
			wk_s2_reg  <= '0;
		end else begin
			rst_s1_reg <= rst_src;
			rst_s2_reg <= rst_s1_reg;
			pin_s1_reg <= external_reset_pin_n;
			pin_s2_reg <= pin_s1_reg;
			wk_s1_reg  <= wake_src;
			wk_s2_reg  <= wk_s1_reg;
		end
	end

	// Decode of events
	assign pin_rst    = !pin_s2_reg;
	assign any_rst    = pin_rst || (|rst_s2_reg);
	assign wr_osc     = reg_write && (reg_addr == `OMRC_ADDR_OSC);
	assign pm_wr      = reg_wdata[`OMRC_PMODE_HI:`OMRC_PMODE_LO];
	assign enter_halt = (state_reg == OMRC_ST_RUN)
		&& (sleep_exec || (wr_osc && pm_wr == `OMRC_PM_HALT));
	assign enter_stby = (state_reg == OMRC_ST_RUN) && wr_osc
		&& (pm_wr == `OMRC_PM_STANDBY);
	assign stby_wake  = |wk_s2_reg;
	assign halt_wake  = wk_s2_reg.wdt_irq || wk_s2_reg.port_b_change_irq
		|| wk_s2_reg.ext_edge_irq;
	// Crystal modes take the long wake wait
	assign is_xtal    = (cfg_reg[`OMRC_CFG_FAST_HI:`OMRC_CFG_FAST_LO] != OMRC_FAST_RC)
		|| cfg_reg[`OMRC_CFG_SLOW_BIT];
	assign wake_cyc   = is_xtal ? CW'(`OMRC_WAKE_XTAL) : CW'(`OMRC_WAKE_RC);

	// Power-up length select
	always_comb begin
		case (cfg_reg[`OMRC_CFG_PWRUP_HI:`OMRC_CFG_PWRUP_LO])
			2'b00:   pwrup_cyc = CW'(PWRUP_A_CYC);
			2'b01:   pwrup_cyc = CW'(PWRUP_B_CYC);
			default: pwrup_cyc = CW'(PWRUP_C_CYC);
		endcase
	end

	// Operating state machine
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= OMRC_ST_RESET;
			cnt_reg   <= '0;
		end else if (any_rst) begin
			state_reg <= OMRC_ST_RESET;
			cnt_reg   <= '0;
		end else begin
			case (state_reg)
				OMRC_ST_RESET: begin
					state_reg <= OMRC_ST_PWRUP;
					cnt_reg   <= pwrup_cyc;
				end
				OMRC_ST_PWRUP: begin
					if (cnt_reg <= CW'(1)) begin
						state_reg <= OMRC_ST_OST;
						cnt_reg   <= CW'(`OMRC_OST_CYCLES);
					end else begin
						cnt_reg <= cnt_reg - CW'(1);
					end
				end
				OMRC_ST_OST: begin
					if (cnt_reg <= CW'(1)) begin
						state_reg <= OMRC_ST_RUN;
					end else begin
						cnt_reg <= cnt_reg - CW'(1);
					end
				end
				OMRC_ST_RUN: begin
					if (enter_halt) begin
						state_reg <= OMRC_ST_HALT;
					end else if (enter_stby) begin
						state_reg <= OMRC_ST_STANDBY;
					end
				end
				OMRC_ST_STANDBY: begin
					if (stby_wake) begin
						state_reg <= OMRC_ST_RUN;
					end
				end
				OMRC_ST_HALT: begin
					if (halt_wake) begin
						state_reg <= OMRC_ST_WAKE;
						cnt_reg   <= wake_cyc;
					end
				end
				OMRC_ST_WAKE: begin
					if (cnt_reg <= CW'(1)) begin
						state_reg <= OMRC_ST_RUN;
					end else begin
						cnt_reg <= cnt_reg - CW'(1);
					end
				end
				default: begin
					state_reg <= OMRC_ST_RESET;
				end
			endcase
		end
	end

	// Vector branch latched at sleep entry
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			vec_reg <= 1'b0;
		end else if (enter_halt || enter_stby) begin
			vec_reg <= global_irq_enable;
		end
	end

	// Oscillator control register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			osc_reg <= `OMRC_OSC_RESET;
		end else if (any_rst || state_reg == OMRC_ST_RESET) begin
			osc_reg <= `OMRC_OSC_RESET;
		end else if (wr_osc) begin
			osc_reg <= reg_wdata;
		end else if ((state_reg == OMRC_ST_STANDBY && stby_wake) || (state_reg == OMRC_ST_WAKE)) begin
			osc_reg[`OMRC_PMODE_HI:`OMRC_PMODE_LO] <= `OMRC_PM_RUN;
		end
	end

	// Configuration word, kept across resets
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg_reg <= `OMRC_CFG_RESET;
		end else if (reg_write && reg_addr == `OMRC_ADDR_CONFIG) begin
			cfg_reg <= reg_wdata;
		end
	end

	// Timeout and powerdown flags
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			to_reg <= 1'b1;
			pd_reg <= 1'b1;
		end else if (rst_s2_reg[2] || rst_s2_reg[1]) begin
			to_reg <= 1'b1;
			pd_reg <= 1'b1;
		end else if (rst_s2_reg[0]) begin
			to_reg <= 1'b0;
			pd_reg <= !(state_reg == OMRC_ST_HALT || state_reg == OMRC_ST_WAKE);
		end else if (pin_rst) begin
			if (state_reg == OMRC_ST_HALT || state_reg == OMRC_ST_WAKE) begin
				to_reg <= 1'b1;
				pd_reg <= 1'b0;
			end
		end else if (enter_halt) begin
			to_reg <= 1'b1;
			pd_reg <= 1'b0;
		end else if (clrwdt_exec && state_reg == OMRC_ST_RUN) begin
			to_reg <= 1'b1;
			pd_reg <= 1'b1;
		end
	end

	// Status word
	always_comb begin
		status_val = 8'h00;
		status_val[`OMRC_PD_BIT] = pd_reg;
		status_val[`OMRC_TO_BIT] = to_reg;
	end

	// Read data one cycle after strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_reg <= 8'h00;
		end else if (reg_read) begin
			case (reg_addr)
				`OMRC_ADDR_OSC:    rdata_reg <= osc_reg;
				`OMRC_ADDR_STATUS: rdata_reg <= status_val;
				`OMRC_ADDR_CONFIG: rdata_reg <= cfg_reg;
				`OMRC_ADDR_MODE:   rdata_reg <= {1'b0, state_reg};
				default:           rdata_reg <= 8'h00;
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	// Clock gating and control outputs
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctl_reg    <= '0;
			rstact_reg <= 1'b1;
		end else begin
			rstact_reg <= !(state_reg == OMRC_ST_RUN || state_reg == OMRC_ST_STANDBY
				|| state_reg == OMRC_ST_HALT || state_reg == OMRC_ST_WAKE);
			ctl_reg <= '0;
			case (state_reg)
				OMRC_ST_RUN: begin
					ctl_reg.fast_osc_en  <= osc_reg[`OMRC_HSEL_BIT]
						|| !osc_reg[`OMRC_HSTOP_BIT];
					ctl_reg.slow_osc_en  <= 1'b1;
					ctl_reg.sys_clk_fast <= osc_reg[`OMRC_HSEL_BIT];
					ctl_reg.cpu_run      <= 1'b1;
					ctl_reg.periph_en    <= 1'b1;
					ctl_reg.timer0_run   <= timer_zero_run_enable;
					ctl_reg.timer1_run   <= timer_one_run_enable;
					ctl_reg.timer0_slow_clk <= osc_reg[`OMRC_HSEL_BIT] && low_clock_to_timer_zero
						&& cfg_reg[`OMRC_CFG_T0SRC_BIT];
					ctl_reg.wdt_clear    <= enter_halt || clrwdt_exec;
				end
				OMRC_ST_STANDBY: begin
					ctl_reg.fast_osc_en  <= !osc_reg[`OMRC_HSTOP_BIT];
					ctl_reg.slow_osc_en  <= 1'b1;
					ctl_reg.sys_clk_fast <= osc_reg[`OMRC_HSEL_BIT];
					ctl_reg.timer0_run   <= timer_zero_run_enable;
					ctl_reg.timer1_run   <= timer_one_run_enable;
					ctl_reg.goto_vector  <= vec_reg && stby_wake;
				end
				OMRC_ST_HALT: begin
					ctl_reg.sys_clk_fast <= osc_reg[`OMRC_HSEL_BIT];
				end
				OMRC_ST_WAKE: begin
					ctl_reg.fast_osc_en  <= 1'b1;
					ctl_reg.slow_osc_en  <= 1'b1;
					ctl_reg.sys_clk_fast <= osc_reg[`OMRC_HSEL_BIT];
					ctl_reg.goto_vector  <= vec_reg && (cnt_reg <= CW'(1));
				end
				default: begin
					ctl_reg.fast_osc_en <= 1'b1;
					ctl_reg.slow_osc_en <= 1'b1;
					ctl_reg.sys_clk_fast <= 1'b1;
				end
			endcase
		end
	end

	assign reg_rdata    = rdata_reg;
	assign ctl          = ctl_reg;
	assign reset_active = rstact_reg;

endmodule : omrc_ctrl

// ### src/omrc_pkg.sv
package omrc_pkg;

	// Operating state, one-hot
	typedef enum logic [6:0] {
		OMRC_ST_RESET   = 7'b000_0001,
		OMRC_ST_PWRUP   = 7'b000_0010,
		OMRC_ST_OST     = 7'b000_0100,
		OMRC_ST_RUN     = 7'b000_1000,
		OMRC_ST_STANDBY = 7'b001_0000,
		OMRC_ST_HALT    = 7'b010_0000,
		OMRC_ST_WAKE    = 7'b100_0000
	} omrc_state_t;

	// Fast oscillator kind
	typedef enum logic [1:0] {
		OMRC_FAST_RC  = 2'b00,
		OMRC_FAST_HXT = 2'b01,
		OMRC_FAST_XT  = 2'b10
	} omrc_fast_t;

	// Wake and reset events
	typedef struct packed {
		logic timer0_irq;
		logic timer1_irq;
		logic wdt_irq;
		logic port_b_change_irq;
		logic ext_edge_irq;
	} omrc_wake_t;

	typedef struct packed {
		logic power_on;
		logic low_voltage;
		logic wdt_reset;
	} omrc_rst_t;

	// Clock and gate outputs
	typedef struct packed {
		logic fast_osc_en;
		logic slow_osc_en;
		logic sys_clk_fast;
		logic cpu_run;
		logic periph_en;
		logic timer0_run;
		logic timer1_run;
		logic timer0_slow_clk;
		logic wdt_clear;
		logic goto_vector;
	} omrc_ctl_t;

endpackage : omrc_pkg
